// ---- core/lrdc_pkg.sv ----
// Package: constants and types for the look-ahead receive descriptor chainer
package lrdc_pkg;
   localparam int unsigned DESC_AW = 8;
   localparam int unsigned LEN_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam logic [DESC_AW-1:0] RING_SIZE_RESET = 8'h09;
   // Descriptor flag bit positions in the status nibble
   localparam int unsigned OWN_BIT = 0;
   localparam int unsigned SOF_BIT = 1;
   localparam int unsigned EOF_BIT = 2;
   localparam int unsigned ERR_BIT = 3;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   // Descriptor write kinds
   typedef enum logic [2:0] {
      LRDC_WR_NONE = 3'h0,
      LRDC_WR_FLAGS = 3'h1
   } lrdc_wr_e;
   typedef enum logic [5:0] {
      LRDC_IDLE = 6'h01,
      LRDC_FETCH = 6'h02,
      LRDC_EVAL = 6'h04,
      LRDC_FILL = 6'h08,
      LRDC_CLOSE = 6'h10,
      LRDC_RELEASE = 6'h20
   } lrdc_state_e;
endpackage

// ---- core/lrdc_fifo_if.sv ----
// Interface: byte stream carrier between FIFO and chaining engine
`timescale 1ns/1ps
`default_nettype none
interface lrdc_fifo_if #(parameter int unsigned WIDTH = 9);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- core/lrdc_fifo.sv ----
// Module: small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module lrdc_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   lrdc_fifo_if.src out
);
   localparam int unsigned AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] count;
   } lrdc_fifo_s;
   lrdc_fifo_s state;
   lrdc_fifo_s next_state;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign in_ready = (state.count != (AW+1)'(DEPTH));
   assign out.valid = (state.count != '0);
   assign out.data = mem[state.rd];
   assign push = enable && in_valid && in_ready;
   assign pop = enable && out.valid && out.ready;

   always_comb begin
      next_state = state;
      if (push) begin
         next_state.wr = (state.wr == AW'(DEPTH-1)) ? '0 : state.wr + 1'b1;
      end
      if (pop) begin
         next_state.rd = (state.rd == AW'(DEPTH-1)) ? '0 : state.rd + 1'b1;
      end
      next_state.count = state.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem[state.wr] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ---- core/lrdc_chain.sv ----
// Module: look-ahead receive descriptor chaining engine (top)
//
// Summary of operation
// R01: Late-owned third descriptor: clear end, own, start
// R02: Unowned third: end in buffer two, skip; the code leaves buffer two closed without an end flag
// R03: Software ignores end flags until next start
// R04: Short frame: end first, release second cleared
// R05: Software resizes only host-owned descriptors
// R06: Early and end-of-frame receive events
// R07: Software sizes first buffer at least 64 bytes
// R08: Software sizes buffers to cover 1518 bytes
// R09: Software converts times at 0.8 us per byte
// R10: New frame starts only in owned start descriptor; without look-ahead the code starts in any owned one
// R11: Searching: owned non-start descriptor released unused
// R12: Skip unowned when searching; chain only owned
// R13: Ring advances cyclically from last used
`timescale 1ns/1ps
`default_nettype none
module lrdc_chain #(
   parameter int unsigned DESC_AW = lrdc_pkg::DESC_AW,
   parameter int unsigned LEN_W = lrdc_pkg::LEN_W,
   parameter int unsigned DATA_W = lrdc_pkg::DATA_W,
   parameter int unsigned FIFO_DEPTH = lrdc_pkg::FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clock_enable,
   input wire logic lookahead_mode_enable,
   input wire logic [DESC_AW-1:0] ring_size,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [DATA_W-1:0] rx_data,
   input wire logic rx_last,
   input wire logic rx_error,
   output logic desc_rd_req,
   output logic [DESC_AW-1:0] desc_index,
   input wire logic desc_rd_ack,
   input wire logic [3:0] desc_flags,
   input wire logic [LEN_W-1:0] desc_size,
   output logic desc_wr_req,
   output logic [3:0] desc_wr_flags,
   input wire logic desc_wr_ack,
   output logic buf_wr_valid,
   output logic [DATA_W-1:0] buf_wr_data,
   output logic [LEN_W-1:0] buf_wr_offset,
   output logic early_receive_interrupt,
   output logic frame_done_interrupt,
   output logic [DESC_AW-1:0] current_index
);
   localparam int unsigned SW = DATA_W + 2;

   // ------------------------------------------------------------
   // Reset release and byte FIFO
   // ------------------------------------------------------------
   logic [1:0] rst_sync;
   logic rst_n_int;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n_int = rst_sync[1];

   lrdc_fifo_if #(.WIDTH(SW)) stream ();
   logic fifo_in_ready;
   logic rx_gate;
   lrdc_fifo #(.WIDTH(SW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rst_n(rst_n_int),
      .enable(clock_enable),
      .in_valid(rx_gate),
      .in_ready(fifo_in_ready),
      .in_data({rx_error, rx_last, rx_data}),
      .out(stream.src)
   );

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      lrdc_pkg::lrdc_state_e fsm;
      logic [DESC_AW-1:0] idx;
      logic [1:0] slot;        // Buffer number within the frame, 0..3, wraps
      logic in_frame;
      logic [LEN_W-1:0] size;
      logic [LEN_W-1:0] offset;
      logic frame_err;
      logic end_here;          // Frame ends in the current buffer
      logic release_next;      // Second descriptor still to be released
      logic rd_req;
      logic wr_req;
      logic [3:0] wr_flags;
      logic rx_ready;
      logic bw_valid;
      logic [DATA_W-1:0] bw_data;
      logic [LEN_W-1:0] bw_off;
      logic early_irq;
      logic done_irq;
   } lrdc_s;
   lrdc_s st;
   lrdc_s next_st;

   logic [DESC_AW-1:0] idx_inc;
   logic own_in;
   logic sof_in;
   logic take;
   logic [DATA_W-1:0] s_data;
   logic s_last;
   logic s_err;
   assign {s_err, s_last, s_data} = stream.data;
   // Bytes enter only while the registered ready stands, so both sides agree
   assign rx_gate = rx_valid && st.rx_ready;
   assign take = st.fsm == lrdc_pkg::LRDC_FILL && stream.valid && st.offset < st.size;
   assign stream.ready = take;
   // Wrap at the programmed ring length, see R13
   assign idx_inc = (st.idx >= ring_size - 1'b1) ? '0 : st.idx + 1'b1;
   assign own_in = desc_flags[lrdc_pkg::OWN_BIT];
   assign sof_in = desc_flags[lrdc_pkg::SOF_BIT];

   always_comb begin
      next_st = st;
      next_st.bw_valid = 1'b0;
      next_st.early_irq = 1'b0;
      next_st.done_irq = 1'b0;
      // Ready drops for a cycle after each push: a registered ready never
      // promises a slot the FIFO lacks, at the price of half the input rate
      next_st.rx_ready = fifo_in_ready && !rx_gate;
      unique case (st.fsm)
         lrdc_pkg::LRDC_IDLE: begin
            if (stream.valid) begin
               next_st.fsm = lrdc_pkg::LRDC_FETCH;
               next_st.rd_req = 1'b1;
            end
         end
         lrdc_pkg::LRDC_FETCH: begin
            if (desc_rd_ack) begin
               next_st.rd_req = 1'b0;
               next_st.fsm = lrdc_pkg::LRDC_EVAL;
            end
         end
         lrdc_pkg::LRDC_EVAL: begin
            next_st.size = desc_size;
            next_st.offset = '0;
            if (st.release_next) begin
               // Short frame: owned second buffer handed back empty, see R04
               next_st.release_next = 1'b0;
               if (own_in) begin
                  next_st.wr_flags = lrdc_pkg::FLAGS_RESET;
                  next_st.wr_req = 1'b1;
                  next_st.fsm = lrdc_pkg::LRDC_RELEASE;
               end else begin
                  next_st.fsm = lrdc_pkg::LRDC_IDLE;
               end
            end else if (!st.in_frame) begin
               if (own_in && (sof_in || !lookahead_mode_enable)) begin
                  // Frame begins here, see R10
                  next_st.in_frame = 1'b1;
                  next_st.slot = 2'h0;
                  next_st.frame_err = 1'b0;
                  next_st.early_irq = 1'b1;   // see R06
                  next_st.fsm = lrdc_pkg::LRDC_FILL;
               end else if (own_in) begin
                  // Discard by dropping ownership only, see R11
                  next_st.wr_flags = lrdc_pkg::FLAGS_RESET;
                  next_st.wr_req = 1'b1;
                  next_st.fsm = lrdc_pkg::LRDC_RELEASE;
               end else begin
                  // Not ours while searching: move on, see R12
                  next_st.idx = idx_inc;
                  next_st.rd_req = 1'b1;
                  next_st.fsm = lrdc_pkg::LRDC_FETCH;
               end
            end else if (own_in) begin
               // Chain into an owned buffer only, see R12; late third is reused, see R01
               next_st.slot = st.slot + 2'h1;
               next_st.fsm = lrdc_pkg::LRDC_FILL;
            end else begin
               // Next buffer unowned: frame is cut, index stays on the untouched descriptor, see R02
               next_st.in_frame = 1'b0;
               next_st.done_irq = 1'b1;
               next_st.fsm = lrdc_pkg::LRDC_IDLE;
            end
         end
         lrdc_pkg::LRDC_FILL: begin
            if (take) begin
               next_st.bw_valid = 1'b1;
               next_st.bw_data = s_data;
               next_st.bw_off = st.offset;
               next_st.offset = st.offset + 1'b1;
               next_st.frame_err = st.frame_err | s_err;
               if (s_last) begin
                  next_st.end_here = 1'b1;
                  next_st.fsm = lrdc_pkg::LRDC_CLOSE;
               end else if (st.offset + 1'b1 == st.size) begin
                  next_st.end_here = 1'b0;
                  next_st.fsm = lrdc_pkg::LRDC_CLOSE;
               end
            end else if (st.size == '0) begin
               next_st.end_here = 1'b0;
               next_st.fsm = lrdc_pkg::LRDC_CLOSE;
            end
         end
         lrdc_pkg::LRDC_CLOSE: begin
            // Own always dropped; start kept only in the first buffer; end flag only where the frame stops, see R01
            next_st.wr_flags = lrdc_pkg::FLAGS_RESET;
            next_st.wr_flags[lrdc_pkg::SOF_BIT] = (st.slot == 2'h0);
            next_st.wr_flags[lrdc_pkg::EOF_BIT] = st.end_here & ~st.frame_err;
            next_st.wr_flags[lrdc_pkg::ERR_BIT] = st.end_here & st.frame_err;
            next_st.wr_req = 1'b1;
            next_st.fsm = lrdc_pkg::LRDC_RELEASE;
         end
         lrdc_pkg::LRDC_RELEASE: begin
            if (desc_wr_ack) begin
               next_st.wr_req = 1'b0;
               next_st.idx = idx_inc;
               if (st.in_frame && st.end_here) begin
                  next_st.in_frame = 1'b0;
                  next_st.end_here = 1'b0;
                  next_st.done_irq = 1'b1;   // see R06
                  // Frame ended in first buffer with look-ahead on: second still to be released, see R04
                  next_st.release_next = (st.slot == 2'h0) && lookahead_mode_enable;
                  next_st.rd_req = next_st.release_next;
                  next_st.fsm = next_st.release_next ? lrdc_pkg::LRDC_FETCH
                                                     : lrdc_pkg::LRDC_IDLE;
               end else if (st.in_frame) begin
                  next_st.rd_req = 1'b1;
                  next_st.fsm = lrdc_pkg::LRDC_FETCH;
               end else begin
                  next_st.fsm = lrdc_pkg::LRDC_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n_int) begin
      if (!rst_n_int) begin
         st <= '0;
         st.fsm <= lrdc_pkg::LRDC_IDLE;
      end else if (clock_enable) begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all registered
   // ------------------------------------------------------------
   assign rx_ready = st.rx_ready;
   assign desc_rd_req = st.rd_req;
   assign desc_index = st.idx;
   assign desc_wr_req = st.wr_req;
   assign desc_wr_flags = st.wr_flags;
   assign buf_wr_valid = st.bw_valid;
   assign buf_wr_data = st.bw_data;
   assign buf_wr_offset = st.bw_off;
   assign early_receive_interrupt = st.early_irq;
   assign frame_done_interrupt = st.done_irq;
   assign current_index = st.idx;
endmodule
`default_nettype wire

// ---- tb/lrdc_chain_asserts.sv ----
// Checker: handshake and flag relations at the chainer's ports
`timescale 1ns/1ps
`default_nettype none
module lrdc_chain_asserts #(
   parameter int unsigned DESC_AW = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic lookahead_mode_enable,
   input wire logic [DESC_AW-1:0] ring_size,
   input wire logic desc_rd_req,
   input wire logic desc_rd_ack,
   input wire logic [3:0] desc_flags,
   input wire logic desc_wr_req,
   input wire logic desc_wr_ack,
   input wire logic [3:0] desc_wr_flags,
   input wire logic [DESC_AW-1:0] desc_index,
   input wire logic early_receive_interrupt,
   input wire logic frame_done_interrupt,
   input wire logic [DESC_AW-1:0] current_index
);
   // ------
   // Properties
   // ------
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_wr_wait;
      desc_wr_req && !desc_wr_ack;
   endsequence
   sequence s_wr_held;
      desc_wr_req && $stable(desc_wr_flags) && $stable(desc_index);
   endsequence
   chk_rd_holds: assert property (desc_rd_req && !desc_rd_ack |=> desc_rd_req)
      else $error("read request dropped early");
   chk_wr_holds: assert property (s_wr_wait |=> s_wr_held)
      else $error("write request not held");
   chk_start_owned: assert property (early_receive_interrupt &&
      lookahead_mode_enable |-> desc_flags[1:0] == 2'h3)
      else $error("frame started in wrong descriptor");
   chk_wr_owned: assert property (desc_wr_req |-> desc_flags[0])
      else $error("write to unowned descriptor");
   chk_wr_release: assert property (desc_wr_req |-> !desc_wr_flags[0])
      else $error("write keeps ownership");
   chk_early_pulse: assert property ($rose(early_receive_interrupt) |=>
      !early_receive_interrupt)
      else $error("early event longer than a cycle");
   chk_done_pulse: assert property (frame_done_interrupt |=> !frame_done_interrupt)
      else $error("done event longer than a cycle");
   chk_index_ring: assert property (current_index < ring_size)
      else $error("index outside ring");
endmodule
`default_nettype wire

// ---- tb/lrdc_host_model.sv ----
// Host memory model: descriptor table answering the chainer's requests
`timescale 1ns/1ps
`default_nettype none
module lrdc_host_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] delay,
   input wire logic desc_rd_req,
   input wire logic desc_wr_req,
   input wire logic [7:0] desc_index,
   input wire logic [3:0] desc_wr_flags,
   output logic desc_rd_ack,
   output logic desc_wr_ack,
   output logic [3:0] desc_flags,
   output logic [15:0] desc_size
);
   localparam logic [15:0] HDR = 16'h0040; // Header-sized first buffer
   localparam logic [15:0] LAT = 16'h0010; // 12.8 us at 0.8 us a byte
   logic [3:0] flags [0:255];
   logic [15:0] buf_size [0:255];
   logic [7:0] wait_n;
   // Only called while the host holds the group
   task automatic arm(input logic [7:0] b, input logic third);
      flags[b] = 4'h3;
      flags[b + 8'h01] = 4'h1;
      flags[b + 8'h02] = {3'h0, third};
      buf_size[b] = HDR;
      buf_size[b + 8'h01] = LAT;
      buf_size[b + 8'h02] = 16'h05EE - HDR - LAT;
   endtask
   // Flags stay as read until the next read answer
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         desc_rd_ack <= 1'h0;
         desc_wr_ack <= 1'h0;
         desc_flags <= 4'h0;
         desc_size <= 16'h0000;
         wait_n <= 8'h00;
      end else if (desc_rd_ack || desc_wr_ack) begin
         desc_rd_ack <= 1'h0;
         desc_wr_ack <= 1'h0;
         wait_n <= 8'h00;
      end else if ((desc_rd_req || desc_wr_req) && wait_n < delay) begin
         wait_n <= wait_n + 8'h01;
      end else if (desc_rd_req) begin
         desc_rd_ack <= 1'h1;
         desc_flags <= flags[desc_index];
         desc_size <= buf_size[desc_index];
      end else if (desc_wr_req) begin
         desc_wr_ack <= 1'h1;
         flags[desc_index] <= desc_wr_flags;
      end
   end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Testbench: frames through the chainer against a queue-based reference
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clock = 1'h0;
   logic rst_n = 1'h0;
   logic clock_enable = 1'h1;
   logic lookahead_mode_enable = 1'h1;
   logic [7:0] ring_size = lrdc_pkg::RING_SIZE_RESET;
   logic rx_valid = 1'h0;
   logic rx_last = 1'h0;
   logic rx_error = 1'h0;
   logic [7:0] rx_data = 8'h00;
   logic [7:0] delay = 8'h00;
   logic rx_ready, desc_rd_req, desc_rd_ack, desc_wr_req, desc_wr_ack, buf_wr_valid;
   logic early_receive_interrupt, frame_done_interrupt;
   logic [7:0] desc_index, current_index, buf_wr_data;
   logic [3:0] desc_flags, desc_wr_flags;
   logic [15:0] desc_size, buf_wr_offset;
   logic [31:0] exp_byte[$], exp_wr[$];
   int err_total = 0, n_tests = 0, n_early = 0, n_done = 0, n_frames = 0;
   lrdc_chain lrdc_chain_i (.*);
   lrdc_host_model lrdc_host_model_i (.*);
   initial begin
      forever #4 clock = ~clock;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      if (err_total == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic fail;
      err_total++;
      summarize();
   endtask
   always @(posedge clock) begin
      if (buf_wr_valid === 1'h1)
         check({desc_index, buf_wr_offset, buf_wr_data}, exp_byte.pop_front());
      if (desc_wr_req === 1'h1 && desc_wr_ack === 1'h1)
         check({20'h0, desc_index, desc_wr_flags}, exp_wr.pop_front());
      n_early += early_receive_interrupt;
      n_done += frame_done_interrupt;
   end
   // ------
   // One frame into group b; a late third write is allowed to trail
   // ------
   task automatic frame(input int len, input logic err, input logic [7:0] b, input logic third);
      int t;
      int lag;
      logic [7:0] k;
      logic [7:0] d;
      lag = (third && len <= 80) ? 1 : 0;
      lrdc_host_model_i.arm(b, third);
      // Without look-ahead an owned descriptor lacking start still takes a frame
      if (lookahead_mode_enable !== 1'h1)
         lrdc_host_model_i.flags[b] = 4'h1;
      if (len <= 64) begin
         exp_wr.push_back({b, err ? 4'hA : 4'h6});
         if (lookahead_mode_enable === 1'h1)
            exp_wr.push_back({b + 8'h01, 4'h0});
      end else begin
         exp_wr.push_back({b, 4'h2});
         exp_wr.push_back({b + 8'h01, len <= 80 ? 4'h4 : 4'h0});
      end
      if (third)
         exp_wr.push_back({b + 8'h02, len > 80 ? 4'h4 : 4'h0});
      for (int i = 0; i < len; i++) begin
         k = (i < 64) ? b : (i < 80 ? b + 8'h01 : b + 8'h02);
         t = (i < 64) ? i : (i < 80 ? i - 64 : i - 80);
         d = 8'($urandom);
         rx_data <= d;
         rx_last <= (i == len - 1);
         rx_error <= err;
         rx_valid <= 1'h1;
         exp_byte.push_back({k, 16'(t), d});
         t = 0;
         do begin
            @(posedge clock);
            t++;
         end while (rx_ready !== 1'h1 && t < 3000);
         if (t >= 3000)
            fail();
      end
      rx_valid <= 1'h0;
      n_frames++;
      t = 0;
      while ((exp_byte.size() > 0 || exp_wr.size() > lag || n_done < n_frames) && t < 3000) begin
         @(posedge clock);
         t++;
      end
      if (t >= 3000)
         fail();
   endtask
   initial begin
      void'($urandom(32'h188D));
      repeat (12) @(posedge clock);
      rst_n <= 1'h1;
      repeat (3) @(posedge clock);
      delay <= 8'($urandom % 4);
      frame(64, 1'h0, 8'h00, 1'h1);
      frame(70, 1'h0, 8'h03, 1'h0);
      frame(70, 1'h0, 8'h06, 1'h1);
      delay <= 8'h18;
      frame(90, 1'h0, 8'h00, 1'h1); // Slow host fills the FIFO
      delay <= 8'($urandom % 4);
      frame(30, 1'h1, 8'h03, 1'h0);
      lookahead_mode_enable <= 1'h0;
      @(posedge clock);
      frame(30, 1'h0, 8'h06, 1'h0);
      repeat (2) @(posedge clock);
      check(32'(n_early), 32'h6);
      check(32'(n_done), 32'h6);
      check(32'(current_index), 32'h7);
      summarize();
   end
endmodule
bind lrdc_chain lrdc_chain_asserts #(.DESC_AW(DESC_AW)) lrdc_chain_asserts_i (.*);
`default_nettype wire
